//--- design/adc_out_pkg.sv
/*
 * Types of the converter output block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package adc_out_pkg;
	// Gray order along run -> down -> redrive -> wake -> run
	typedef enum logic [1:0] {
		PWR_RUN     = 2'b00,
		PWR_DOWN    = 2'b01,
		PWR_REDRIVE = 2'b11,
		PWR_WAKE    = 2'b10
	} pwr_state_t;
endpackage
`default_nettype wire

//--- design/adc_out_regs.svh
/*
 * Constants of the converter output block: register map, field positions,
 * reset values, code values and timing figures.
 * Assumes it is included by bare name from design and verification files.
 */
`ifndef ADC_OUT_REGS_SVH
`define ADC_OUT_REGS_SVH

`define ADC_CODE_W        14
`define ADC_RAW_W         16
`define ADC_PIPE_STAGES   9
`define ADC_TC_POS_FS     14'h1FFF
`define ADC_TC_NEG_FS     14'h2000
`define ADC_MSB_FLIP      14'h2000
`define ADC_RAW_POS_FS    16'sh1FFF
`define ADC_RAW_NEG_FS    16'shE000

`define ADC_CLK_PERIOD_NS 8
`define ADC_FLOAT_NS      10
`define ADC_WAKE_MS       10
`define ADC_NS_PER_MS     1000000
`define ADC_CONV_HALF     4

`define ADC_ADDR_W        8
`define ADC_OFS_CTRL      8'h00
`define ADC_OFS_STATUS    8'h04
`define ADC_OFS_INT_STAT  8'h08
`define ADC_OFS_INT_MASK  8'h0C
`define ADC_OFS_LAST      8'h10

`define ADC_CTRL_FORCE_PD 0
`define ADC_STAT_PD       0
`define ADC_STAT_SETTLED  1
`define ADC_STAT_GRAY     2
`define ADC_INT_OVR       0
`define ADC_INT_WAKE      1
`define ADC_INT_PD        2
`define ADC_INT_W         3
`define ADC_LAST_OVR      14

`define ADC_CTRL_RST      1'h0
`define ADC_INT_RST       3'h0

`endif

//--- design/adc_output_coding.sv
/*
 * Digital output side of a 14-bit pipelined converter: output coding,
 * over-range flag, data-valid strobe, power-down with floating outputs,
 * APB registers and a level interrupt.
 * Assumes the quantizer presents a signed code on pclk each cycle and the
 * pins power_down_select and gray_select are asynchronous.
 */
// Implementation choices: the placing of the registers and the APB slave port.
`default_nettype none
`include "adc_out_regs.svh"

////////////////////////////////////////////////////////////////////////////
// Function
// - Conversion runs while power-down select is low and stops when high.
// - In power-down the data bus, over-range flag and strobe all float.
// - In power-down all logic halts and no new results appear; here the pin synchronisers, APB registers and interrupt keep running.
// - Two's complement gives 0x1FFF at plus and 0x2000 at minus scale.
// - Gray output is the Gray code of offset binary, midscale 0x3000.
// - Out-of-range input sets the flag and clamps to the full-scale code.
// - Format select high gives Gray code, low gives two's complement.
// - Each result appears 8.5 conversion cycles after its sampling edge.
// - Outputs change on the strobe's fall; the capturer latches on rise.
// - The flag floats and redrives within 10 ns of power-down edges; here it floats three and redrives four pclk edges after the pin.
module adc_output_coding #(
	parameter int WAKE_CYCLES = `ADC_WAKE_MS * (`ADC_NS_PER_MS
		/ `ADC_CLK_PERIOD_NS),
	parameter int CONV_HALF   = `ADC_CONV_HALF
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic [`ADC_ADDR_W-1:0]  paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic                         pready,
	output logic      [31:0]             prdata,
	output logic                         pslverr,
	input  wire logic                    power_down_select,
	input  wire logic                    gray_select,
	input  wire logic [`ADC_RAW_W-1:0]   quantizer_code,
	output logic                         sample_take,
	output logic      [`ADC_CODE_W-1:0]  conversion_data_bus,
	output logic                         conversion_data_bus_oe_n,
	output logic                         over_range_flag,
	output logic                         over_range_flag_oe_n,
	output logic                         data_valid_strobe,
	output logic                         data_valid_strobe_oe_n,
	output logic                         irq
);
	localparam int FLOOR_CYC = `ADC_FLOAT_NS / `ADC_CLK_PERIOD_NS;
	localparam int REDRIVE_CYC = (FLOOR_CYC < 1) ? 1 : FLOOR_CYC;
	localparam int CW = `ADC_CODE_W;

	function automatic logic [CW-1:0] to_gray(input logic [CW-1:0] tc);
		logic [CW-1:0] ob;
		ob = tc ^ `ADC_MSB_FLIP;
		return ob ^ (ob >> 1);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic pd_meta, pd_sync, gs_meta, gs_sync;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_meta <= 1'b0;
			pd_sync <= 1'b0;
			gs_meta <= 1'b0;
			gs_sync <= 1'b0;
		end else begin
			pd_meta <= power_down_select;
			pd_sync <= pd_meta;
			gs_meta <= gray_select;
			gs_sync <= gs_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state
	logic                    force_pd;
	adc_out_pkg::pwr_state_t state, next_state;
	logic [31:0]             cnt, next_cnt;
	logic                    pd_req, driving, ev_wake, ev_pd;

	assign pd_req = pd_sync | force_pd;

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		ev_wake    = 1'b0;
		ev_pd      = 1'b0;
		case (state)
			adc_out_pkg::PWR_RUN, adc_out_pkg::PWR_WAKE: begin
				if (pd_req) begin
					next_state = adc_out_pkg::PWR_DOWN;
					ev_pd      = 1'b1;
				end else if (state == adc_out_pkg::PWR_WAKE) begin
					if (cnt == 32'h0) begin
						next_state = adc_out_pkg::PWR_RUN;
						ev_wake    = 1'b1;
					end else begin
						next_cnt = cnt - 32'h1;
					end
				end
			end
			adc_out_pkg::PWR_DOWN: begin
				if (!pd_req) begin
					next_state = adc_out_pkg::PWR_REDRIVE;
					next_cnt   = 32'(REDRIVE_CYC - 1);
				end
			end
			adc_out_pkg::PWR_REDRIVE: begin
				if (pd_req) begin
					next_state = adc_out_pkg::PWR_DOWN;
				end else if (cnt == 32'h0) begin
					next_state = adc_out_pkg::PWR_WAKE;
					next_cnt   = 32'(WAKE_CYCLES - 1);
				end else begin
					next_cnt = cnt - 32'h1;
				end
			end
			default: begin
				next_state = adc_out_pkg::PWR_DOWN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= adc_out_pkg::PWR_RUN;
			cnt   <= 32'h0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	assign driving = (state == adc_out_pkg::PWR_RUN) ||
		(state == adc_out_pkg::PWR_WAKE);

	////////////////////////////////////////////////////////////////////////
	// Conversion clock enable, sampling and coding
	logic [15:0]   div_cnt, next_div_cnt;
	logic          conv_level, next_conv_level;
	logic          tick, conv_fall, conv_rise;
	logic          raw_over;
	logic [CW-1:0] raw_tc;
	logic [CW:0]   pipe_out;

	assign tick      = driving && (div_cnt == 16'(CONV_HALF - 1));
	assign conv_fall = tick && conv_level;
	assign conv_rise = tick && !conv_level;

	always_comb begin
		next_div_cnt    = div_cnt + 16'h1;
		next_conv_level = conv_level;
		if (!driving) begin
			// Halted divider restarts high, so the first edge is a fall
			next_div_cnt    = 16'h0;
			next_conv_level = 1'b1;
		end else if (tick) begin
			next_div_cnt    = 16'h0;
			next_conv_level = !conv_level;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt    <= 16'h0;
			conv_level <= 1'b1;
		end else begin
			div_cnt    <= next_div_cnt;
			conv_level <= next_conv_level;
		end
	end

	assign sample_take = conv_fall;

	always_comb begin
		raw_over = 1'b0;
		raw_tc   = quantizer_code[CW-1:0];
		if ($signed(quantizer_code) > `ADC_RAW_POS_FS) begin
			raw_over = 1'b1;
			raw_tc   = `ADC_TC_POS_FS;
		end else if ($signed(quantizer_code) < `ADC_RAW_NEG_FS) begin
			raw_over = 1'b1;
			raw_tc   = `ADC_TC_NEG_FS;
		end
	end

	// Nine falls of shift plus the following rise give 8.5 cycles
	sample_delay_line #(
		.WIDTH (CW + 1),
		.DEPTH (`ADC_PIPE_STAGES)
	) u_pipe (
		.clk   (pclk),
		.rst_n (presetn),
		.shift (conv_fall),
		.clear (!driving),
		.din   ({raw_over, raw_tc}),
		.dout  (pipe_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Output registers
	logic [CW-1:0] next_data;
	logic          next_over, next_strobe, ev_ovr;

	always_comb begin
		next_data   = conversion_data_bus;
		next_over   = over_range_flag;
		ev_ovr      = 1'b0;
		// Strobe follows the inverted conversion clock, so data moves
		// on its falling edge and is steady across its rise
		next_strobe = driving && !next_conv_level;
		if (conv_rise) begin
			next_over = pipe_out[CW];
			ev_ovr    = pipe_out[CW];
			if (gs_sync) begin
				next_data = to_gray(pipe_out[CW-1:0]);
			end else begin
				next_data = pipe_out[CW-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_data_bus <= '0;
			over_range_flag     <= 1'b0;
			data_valid_strobe   <= 1'b0;
		end else begin
			conversion_data_bus <= next_data;
			over_range_flag     <= next_over;
			data_valid_strobe   <= next_strobe;
		end
	end

	// Enables float from the cycle the state leaves driving
	assign conversion_data_bus_oe_n = !driving;
	assign over_range_flag_oe_n     = !driving;
	assign data_valid_strobe_oe_n   = !driving;

	////////////////////////////////////////////////////////////////////////
	// APB registers and interrupt
	logic                   setup, wr, addr_ok;
	logic [`ADC_INT_W-1:0]  int_stat, int_mask, next_int_stat, next_int_mask;
	logic                   next_force_pd;
	logic [31:0]            rd_mux;

	assign setup   = psel && !penable;
	assign wr      = psel && penable && pwrite;
	assign addr_ok = (paddr == `ADC_OFS_CTRL) ||
		(paddr == `ADC_OFS_STATUS) || (paddr == `ADC_OFS_INT_STAT) ||
		(paddr == `ADC_OFS_INT_MASK) || (paddr == `ADC_OFS_LAST);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			`ADC_OFS_CTRL:     rd_mux[`ADC_CTRL_FORCE_PD] = force_pd;
			`ADC_OFS_STATUS: begin
				rd_mux[`ADC_STAT_PD]      = !driving;
				rd_mux[`ADC_STAT_SETTLED] = state == adc_out_pkg::PWR_RUN;
				rd_mux[`ADC_STAT_GRAY]    = gs_sync;
			end
			`ADC_OFS_INT_STAT: rd_mux[`ADC_INT_W-1:0] = int_stat;
			`ADC_OFS_INT_MASK: rd_mux[`ADC_INT_W-1:0] = int_mask;
			`ADC_OFS_LAST: begin
				rd_mux[CW-1:0]        = conversion_data_bus;
				rd_mux[`ADC_LAST_OVR] = over_range_flag;
			end
			default:           rd_mux = 32'h0;
		endcase
	end

	always_comb begin
		next_force_pd = force_pd;
		next_int_mask = int_mask;
		next_int_stat = int_stat;
		if (wr && paddr == `ADC_OFS_CTRL) begin
			next_force_pd = pwdata[`ADC_CTRL_FORCE_PD];
		end
		if (wr && paddr == `ADC_OFS_INT_MASK) begin
			next_int_mask = pwdata[`ADC_INT_W-1:0];
		end
		if (wr && paddr == `ADC_OFS_INT_STAT) begin
			next_int_stat = int_stat & ~pwdata[`ADC_INT_W-1:0];
		end
		// Set after clear, so an event in the clearing cycle survives
		next_int_stat[`ADC_INT_OVR]  = next_int_stat[`ADC_INT_OVR] | ev_ovr;
		next_int_stat[`ADC_INT_WAKE] = next_int_stat[`ADC_INT_WAKE] | ev_wake;
		next_int_stat[`ADC_INT_PD]   = next_int_stat[`ADC_INT_PD] | ev_pd;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_pd <= `ADC_CTRL_RST;
			int_stat <= `ADC_INT_RST;
			int_mask <= `ADC_INT_RST;
			prdata   <= 32'h0;
		end else begin
			force_pd <= next_force_pd;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			if (setup && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	assign irq = |(int_stat & int_mask);
endmodule
`default_nettype wire

//--- design/sample_delay_line.sv
/*
 * Shift memory holding conversion results in flight through the pipeline.
 * Assumes shift and clear come from logic on the same clock.
 */
`default_nettype none
module sample_delay_line #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 9
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             shift,
	input  wire logic             clear,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage      [DEPTH];
	logic [WIDTH-1:0] next_stage [DEPTH];

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			next_stage[i] = stage[i];
		end
		if (clear) begin
			for (int i = 0; i < DEPTH; i++) begin
				next_stage[i] = '0;
			end
		end else if (shift) begin
			next_stage[0] = din;
			for (int i = 1; i < DEPTH; i++) begin
				next_stage[i] = stage[i-1];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= next_stage[i];
			end
		end
	end

	// Read port is the last stage itself, already a register
	assign dout = stage[DEPTH-1];
endmodule
`default_nettype wire

//--- verif/adc_output_coding_properties.sv
/* Checker of the converter output block: timing, clamping, floating.
   Assumes binding to adc_output_coding with CONV_HALF of 4. */
`default_nettype none
`include "adc_out_regs.svh"
////////////////////////////////////////////////////////////////////////
module adc_output_coding_checker #(
	parameter int CONV_HALF = 4
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   power_down_select,
	input wire logic [`ADC_RAW_W-1:0]  quantizer_code,
	input wire logic                   sample_take,
	input wire logic [`ADC_CODE_W-1:0] conversion_data_bus,
	input wire logic                   conversion_data_bus_oe_n,
	input wire logic                   over_range_flag,
	input wire logic                   over_range_flag_oe_n,
	input wire logic                   data_valid_strobe,
	input wire logic                   data_valid_strobe_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Output register moves at the 68th edge and is sampled one edge later
	localparam int LAT = 17 * CONV_HALF + 1;
	logic quiet;
	logic wild;
	assign quiet = !presetn || power_down_select || conversion_data_bus_oe_n;
	assign wild = $signed(quantizer_code) > 16'sh1FFF ||
		$signed(quantizer_code) < 16'shE000;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_float_together:
		assert property (conversion_data_bus_oe_n == over_range_flag_oe_n &&
			conversion_data_bus_oe_n == data_valid_strobe_oe_n)
		else $error("output enables differ");
	a_pin_floats:
		assert property (power_down_select [*5] |-> conversion_data_bus_oe_n)
		else $error("bus driven while powered down");
	a_halt_all:
		assert property ($past(conversion_data_bus_oe_n) &&
			conversion_data_bus_oe_n |-> !sample_take && !data_valid_strobe)
		else $error("activity while powered down");
	a_sample_period:
		assert property (disable iff (quiet)
			sample_take |=> !sample_take [*7] ##1 sample_take)
		else $error("sampling period wrong");
	a_change_on_fall:
		assert property (disable iff (quiet)
			$changed(conversion_data_bus) |-> $fell(data_valid_strobe))
		else $error("bus changed off strobe fall");
	a_strobe_rise:
		assert property (disable iff (quiet)
			$fell(data_valid_strobe) |-> !data_valid_strobe [*4] ##1
			data_valid_strobe)
		else $error("strobe high phase misplaced");
	a_result_latency:
		assert property (disable iff (quiet)
			sample_take |-> ##LAT $fell(data_valid_strobe))
		else $error("result latency wrong");
	a_clamp_flag:
		assert property (disable iff (quiet) sample_take && wild |-> ##LAT
			over_range_flag && conversion_data_bus inside
			{14'h1FFF, 14'h2000, 14'h0000})
		else $error("out of range sample not clamped");
	a_flag_clear:
		assert property (disable iff (quiet)
			sample_take && !wild |-> ##LAT !over_range_flag)
		else $error("flag set for in range sample");
	cover property (sample_take && wild);
	cover property ($rose(conversion_data_bus_oe_n));
	cover property ($fell(conversion_data_bus_oe_n));
endmodule
bind adc_output_coding adc_output_coding_checker #(.CONV_HALF(CONV_HALF))
	u_chk (.pclk, .presetn, .power_down_select, .quantizer_code,
	.sample_take, .conversion_data_bus, .conversion_data_bus_oe_n,
	.over_range_flag, .over_range_flag_oe_n, .data_valid_strobe,
	.data_valid_strobe_oe_n);
`default_nettype wire

//--- verif/adc_output_coding_tb.sv
/* Bench of the converter output block: APB registers, coding table,
   interrupt and power-down. Assumes checker and capture model exist. */
`default_nettype none
`include "adc_out_regs.svh"
////////////////////////////////////////////////////////////////////////
module adc_output_coding_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0;
	logic presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic power_down_select, gray_select, sample_take, over_range_flag;
	logic data_valid_strobe, conversion_data_bus_oe_n, over_range_flag_oe_n;
	logic data_valid_strobe_oe_n;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] quantizer_code;
	logic [13:0] conversion_data_bus;
	logic [14:0] captured;
	int count, n, err_total, tests_run;
	localparam logic [15:0] TV [7] = '{16'h0000, 16'h0001, 16'hFFFF,
		16'h1FFF, 16'hE000, 16'h2328, 16'hDCD8};
	localparam logic [14:0] TC [7] = '{15'h0000, 15'h0001, 15'h3FFF,
		15'h1FFF, 15'h2000, 15'h5FFF, 15'h6000};
	localparam logic [14:0] GC [7] = '{15'h3000, 15'h3001, 15'h1000,
		15'h2000, 15'h0000, 15'h6000, 15'h4000};
	always #4 pclk = ~pclk;
	adc_output_coding #(.WAKE_CYCLES(20)) DUT (.pclk, .presetn, .paddr,
		.psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
		.power_down_select, .gray_select, .quantizer_code, .sample_take,
		.conversion_data_bus, .conversion_data_bus_oe_n, .over_range_flag,
		.over_range_flag_oe_n, .data_valid_strobe, .data_valid_strobe_oe_n,
		.irq);
	sample_capture #(.SETTLE(100)) cap (.pclk,
		.bus_oe_n(conversion_data_bus_oe_n), .code_in(conversion_data_bus),
		.flag_in(over_range_flag), .strobe_in(data_valid_strobe),
		.captured, .count);
	task automatic check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Return one edge later, so callers drive on edges and see writes
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, string s);
		apb(1'h0, a, 32'h0);
		check(s, r, x);
	endtask
	task automatic floats(input logic [2:0] x);
		check("enables", {29'h0, conversion_data_bus_oe_n,
			over_range_flag_oe_n, data_valid_strobe_oe_n}, {29'h0, x});
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100us;
		err_total++;
		results();
	end
	initial begin
		{presetn, psel, penable, pwrite} = '0;
		{power_down_select, gray_select, paddr, pwdata} = '0;
		quantizer_code = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		rd(8'h04, 32'h2, "status");
		rd(8'h0C, 32'h0, "mask");
		rd(8'h20, 32'h0, "unmapped");
		check("slverr", {31'h0, e}, 32'h1);
		check("pready", {31'h0, pready}, 32'h1);
		for (int g = 0; g < 2; g++)
			for (int i = 0; i < 7; i++) begin
				gray_select <= g[0];
				quantizer_code <= TV[i];
				repeat (90) @(posedge pclk);
				check("code", {17'h0, captured},
					g ? GC[i] : TC[i]);
				rd(8'h10, {17'h0, g ? GC[i] : TC[i]}, "last");
			end
		gray_select <= 1'h0;
		quantizer_code <= 16'h0000;
		repeat (90) @(posedge pclk);
		rd(8'h08, 32'h1, "int_stat");
		check("irq masked", {31'h0, irq}, 32'h0);
		apb(1'h1, 8'h0C, 32'h1);
		check("irq", {31'h0, irq}, 32'h1);
		apb(1'h1, 8'h08, 32'h1);
		check("irq cleared", {31'h0, irq}, 32'h0);
		power_down_select <= 1'h1;
		repeat (6) @(posedge pclk);
		#1 floats(3'h7);
		n = count;
		rd(8'h04, 32'h1, "status down");
		quantizer_code <= 16'h0001;
		repeat (100) @(posedge pclk);
		check("halted", count, n);
		rd(8'h10, 32'h0, "frozen");
		power_down_select <= 1'h0;
		repeat (6) @(posedge pclk);
		#1 floats(3'h0);
		repeat (250) @(posedge pclk);
		check("resumed", {31'h0, count > n}, 32'h1);
		check("wake code", {17'h0, captured}, 32'h1);
		rd(8'h08, 32'h6, "int_stat wake");
		rd(8'h04, 32'h2, "status run");
		apb(1'h1, 8'h00, 32'h1);
		repeat (6) @(posedge pclk);
		#1 floats(3'h7);
		rd(8'h00, 32'h1, "ctrl");
		apb(1'h1, 8'h00, 32'h0);
		results();
	end
endmodule
`default_nettype wire

//--- verif/sample_capture.sv
/* Back-end capture logic latching each result on the strobe rise once SETTLE driven cycles have passed.
   Assumes its pins come straight from the converter outputs. */
`default_nettype none
`include "adc_out_regs.svh"
////////////////////////////////////////////////////////////////////////
module sample_capture #(
	parameter int SETTLE = 100
) (
	input  wire logic                   pclk,
	input  wire logic                   bus_oe_n,
	input  wire logic [`ADC_CODE_W-1:0] code_in,
	input  wire logic                   flag_in,
	input  wire logic                   strobe_in,
	output logic      [`ADC_CODE_W:0]   captured = '0,
	output int                          count = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic toggle = 1'h0;
	logic prev = 1'h0;
	int   wake = 0;
	logic [`ADC_CODE_W:0] line;
	logic strobe_line;
	// Floating pins show no stale value, so a bad enable is seen
	assign line = bus_oe_n ? ~captured : {flag_in, code_in};
	assign strobe_line = bus_oe_n ? toggle : strobe_in;
	always @(posedge pclk) begin
		toggle <= ~toggle;
		prev <= strobe_line;
		// Floating pins restart the settling count
		if (bus_oe_n) begin
			wake <= 0;
		end else if (wake < SETTLE) begin
			wake <= wake + 1;
		end
		if (strobe_line && !prev && !bus_oe_n &&
			wake >= SETTLE) begin
			captured <= line;
			count <= count + 1;
		end
	end
endmodule
`default_nettype wire
